// ===== sense_pkg.sv
/*
  Shared constants and types for the capacitive sense channel select block:
  register offsets, field positions, reset values and the packed carriers.
  Assumes a 32-bit APB slave with byte addresses and one word per register.
*/

`default_nettype none

package sense_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_SENSE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SENSE_CHANNEL = 8'h04;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in sense_control_reg
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_RANGE_HI = 3;
  localparam int CTRL_RANGE_LO = 2;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_TMR_SEL_BIT = 0;

  // Field positions in sense_channel_reg
  localparam int CHAN_HI = 3;
  localparam int CHAN_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and reset values
  localparam int NUM_CHANNELS = 12;
  localparam int CHAN_W = 4;
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [3:0] CHANNEL_RESET = 4'h0;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic TMR_SEL_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic module_enable;
    logic [1:0] osc_range;
    logic timer_ext_clk_select;
  } control_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic osc_enable;
    logic [1:0] osc_range;
    logic timer_clk_from_osc;
  } osc_ctrl_t;

endpackage : sense_pkg

`default_nettype wire

// ===== level_sync.sv
/*
  Two-flop synchroniser for a single level from outside the clock domain.
  Assumes the input changes slowly compared with the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module level_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;

  // The first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : level_sync

`default_nettype wire

// ===== channel_decoder.sv
/*
  Registered one-hot decoder from a binary channel index to sense pin selects.
  Assumes index and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module channel_decoder #(
  parameter int NUM_CHANNELS = sense_pkg::NUM_CHANNELS,
  parameter int CHAN_W = sense_pkg::CHAN_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [CHAN_W-1:0] index,
  output logic [NUM_CHANNELS-1:0] pin_select
);

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_pin
      // Codes beyond the last channel match no pin, so reserved codes connect nothing
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_select[g] <= 1'b0;
        end else begin
          pin_select[g] <= enable && (index == CHAN_W'(g));
        end
      end
    end
  endgenerate

endmodule : channel_decoder

`default_nettype wire

// ===== cap_sense_channel_select.sv
/*
  Capacitive sense channel select: APB register file with the sense control
  and channel registers, the one-hot sense pin selection, the oscillator
  control outputs and the timer clock source steering.
  Assumes a single 100 MHz clock, a synchronous active-high reset and an
  oscillator direction level that arrives from the analog side unsynchronised.
*/
`timescale 1ns/1ps
`default_nettype none

module cap_sense_channel_select #(
  parameter int NUM_CHANNELS = sense_pkg::NUM_CHANNELS,
  parameter int CHAN_W = sense_pkg::CHAN_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sense_pkg::ADDR_W-1:0] paddr,
  input wire logic [sense_pkg::DATA_W-1:0] pwdata,
  output logic [sense_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_direction_raw,
  input wire logic timer_clock_source,
  output logic [NUM_CHANNELS-1:0] sense_pin_select,
  output sense_pkg::osc_ctrl_t osc_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths

  function automatic logic is_control(input logic [sense_pkg::ADDR_W-1:0] a);
    is_control = (a == sense_pkg::ADDR_SENSE_CONTROL);
  endfunction : is_control

  function automatic logic is_channel(input logic [sense_pkg::ADDR_W-1:0] a);
    is_channel = (a == sense_pkg::ADDR_SENSE_CHANNEL);
  endfunction : is_channel

  ////////////////////////////////////////////////////////////////////////////
  // Bus request carrier

  sense_pkg::apb_req_t req;
  logic setup_phase;
  logic access_done;
  logic mapped;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};
  assign setup_phase = req.psel && !req.penable;
  // pready is raised on the first access cycle, so a transfer takes two cycles
  assign access_done = req.psel && req.penable && pready;
  assign mapped = is_control(req.paddr) || is_channel(req.paddr);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  sense_pkg::control_t control;
  logic [CHAN_W-1:0] channel_index;
  logic osc_direction;

  // Writes land only at the completing edge of the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control.module_enable <= sense_pkg::ENABLE_RESET;
      control.osc_range <= sense_pkg::RANGE_RESET;
      control.timer_ext_clk_select <= sense_pkg::TMR_SEL_RESET;
    end else if (access_done && req.pwrite && is_control(req.paddr)) begin
      control.module_enable <= req.pwdata[sense_pkg::CTRL_ENABLE_BIT];
      control.osc_range <= req.pwdata[sense_pkg::CTRL_RANGE_HI:sense_pkg::CTRL_RANGE_LO];
      control.timer_ext_clk_select <= req.pwdata[sense_pkg::CTRL_TMR_SEL_BIT];
    end
  end

  // Reserved codes are stored as written; the decoder maps them to no pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_index <= sense_pkg::CHANNEL_RESET;
    end else if (access_done && req.pwrite && is_channel(req.paddr)) begin
      channel_index <= req.pwdata[sense_pkg::CHAN_HI:sense_pkg::CHAN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator direction from the analog side

  logic direction_sync;

  level_sync u_dir_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(osc_direction_raw),
    .sync_out(direction_sync)
  );

  // A stopped oscillator neither sources nor sinks, so the bit reads low then
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_direction <= 1'b0;
    end else begin
      osc_direction <= osc_ctrl.osc_enable && direction_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus answer

  logic [sense_pkg::DATA_W-1:0] next_prdata;

  always_comb begin
    next_prdata = '0;
    if (is_control(req.paddr)) begin
      next_prdata[sense_pkg::CTRL_ENABLE_BIT] = control.module_enable;
      next_prdata[sense_pkg::CTRL_RANGE_HI:sense_pkg::CTRL_RANGE_LO] = control.osc_range;
      next_prdata[sense_pkg::CTRL_DIR_BIT] = osc_direction;
      next_prdata[sense_pkg::CTRL_TMR_SEL_BIT] = control.timer_ext_clk_select;
    end else if (is_channel(req.paddr)) begin
      next_prdata[sense_pkg::CHAN_HI:sense_pkg::CHAN_LO] = channel_index;
    end
  end

  // Read data is captured in the setup cycle and held through the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= req.pwrite ? '0 : next_prdata;
    end
  end

  // One wait-free access cycle: pready stands for exactly that cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense pin selection

  channel_decoder #(
    .NUM_CHANNELS(NUM_CHANNELS),
    .CHAN_W(CHAN_W)
  ) u_decoder (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(control.module_enable),
    .index(channel_index),
    .pin_select(sense_pin_select)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator and timer clock steering

  // Range is forced off while the module is disabled so no current flows
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_ctrl.osc_enable <= 1'b0;
      osc_ctrl.osc_range <= sense_pkg::RANGE_OFF;
    end else begin
      osc_ctrl.osc_enable <= control.module_enable &&
                             (control.osc_range != sense_pkg::RANGE_OFF);
      osc_ctrl.osc_range <= control.module_enable ? control.osc_range
                                                  : sense_pkg::RANGE_OFF;
    end
  end

  // Only matters while the timer itself is set to an external clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_ctrl.timer_clk_from_osc <= 1'b0;
    end else begin
      osc_ctrl.timer_clk_from_osc <= timer_clock_source &&
                                     control.timer_ext_clk_select;
    end
  end

endmodule : cap_sense_channel_select

`default_nettype wire

// ===== cap_sense_sva.sv
/* Concurrent checks on the ports of cap_sense_channel_select.
   Assumes an APB master that holds every request until pready. */
`timescale 1ns/1ps
`default_nettype none
module cap_sense_sva #(
  parameter int NUM_CHANNELS = 12,
  parameter int CHAN_W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_direction_raw,
  input wire logic timer_clock_source,
  input wire logic [NUM_CHANNELS-1:0] sense_pin_select,
  input wire sense_pkg::osc_ctrl_t osc_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire mapped = (paddr == 8'h00) || (paddr == 8'h04);
  logic [1:0] rng_q;
  // Range of the last accepted control write, kept because pwdata is released
  always_ff @(posedge clk) begin
    if (sys_rst) rng_q <= 2'h0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00) rng_q <= pwdata[3:2];
  end
  sequence acc; psel && penable && pready; endsequence
  sequence wr_ctrl; acc ##0 (pwrite && paddr == 8'h00); endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ready_next:
    assert property (psel && !penable |=> pready) else $error("pready late");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_err_unmapped:
    assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  a_read_zero_hi:
    assert property (acc ##0 !pwrite |-> prdata[31:8] == 24'h0 && (paddr != 8'h00 ||
      prdata[6:4] == 3'h0) && (paddr != 8'h04 || prdata[7:4] == 4'h0)) else $error("rsvd bits");
  a_pins_onehot:
    assert property ($onehot0(sense_pin_select)) else $error("several pins");
  a_off_no_pins:
    assert property (wr_ctrl ##0 !pwdata[7] |-> ##2 (sense_pin_select == '0 &&
      !osc_ctrl.osc_enable)) else $error("pins while off");
  a_range_follow:
    assert property (wr_ctrl ##0 pwdata[7] |-> ##2 (osc_ctrl.osc_range == rng_q &&
      osc_ctrl.osc_enable == (rng_q != 2'h0))) else $error("range wrong");
  a_timer_off:
    assert property (wr_ctrl ##0 !pwdata[0] |-> ##2 !osc_ctrl.timer_clk_from_osc)
      else $error("timer clock steered");
  a_reset_clear:
    assert property (disable iff (1'b0) sys_rst |=> sense_pin_select == '0 &&
      osc_ctrl == '0 && !pready) else $error("reset state");
endmodule : cap_sense_sva
bind cap_sense_channel_select cap_sense_sva #(.NUM_CHANNELS(NUM_CHANNELS), .CHAN_W(CHAN_W))
  cap_sense_sva_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .osc_direction_raw(osc_direction_raw),
  .timer_clock_source(timer_clock_source), .sense_pin_select(sense_pin_select),
  .osc_ctrl(osc_ctrl));
`default_nettype wire

// ===== tb_cap_sense_channel_select.sv
/* Self-checking bench for cap_sense_channel_select over APB.
   Assumes the package, design and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_cap_sense_channel_select;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic osc_direction_raw = 1'b0;
  logic timer_clock_source = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] sense_pin_select;
  sense_pkg::osc_ctrl_t osc_ctrl;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic er;
  always #5 clk = ~clk;
  cap_sense_channel_select cap_sense_channel_select_inst (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_direction_raw(osc_direction_raw),
    .timer_clock_source(timer_clock_source), .sense_pin_select(sense_pin_select),
    .osc_ctrl(osc_ctrl));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  // No cycle count is assumed: the wait ends on pready, the watchdog bounds it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Register-driven outputs land one edge after the accepting edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic osc_is(input logic [3:0] x);
    settle();
    check("osc_ctrl", {28'h0, osc_ctrl}, {28'h0, x});
  endtask : osc_is
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0); check("channel", rd, 32'h0);
    check("pins", {20'h0, sense_pin_select}, 32'h0);
    osc_is(4'h0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_channels();
    apb(1'b1, 8'h00, 32'h84);
    // Software keeps away from the reserved codes 12 to 15
    for (int c = 0; c < sense_pkg::NUM_CHANNELS; c++) begin
      apb(1'b1, 8'h04, 32'hfffffff0 | c);
      settle();
      check("pins", {20'h0, sense_pin_select}, 32'h1 << c);
      apb(1'b0, 8'h04, 32'h0); check("channel", rd, c);
    end
    $display("test channels done");
  endtask : test_channels
  task automatic test_enable_range();
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h00, 32'h0c);
    osc_is(4'h0); check("pins", {20'h0, sense_pin_select}, 32'h0);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h00, 32'h80 | (r << 2));
      osc_is({r != 0, r[1:0], 1'b0}); check("pins", {20'h0, sense_pin_select}, 32'h20);
    end
    $display("test enable range done");
  endtask : test_enable_range
  task automatic test_status();
    apb(1'b1, 8'h00, 32'hff); apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h8d);
    osc_direction_raw <= 1'b1;
    timer_clock_source <= 1'b1;
    osc_is(4'hf);
    apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h8f);
    apb(1'b1, 8'h00, 32'h0f);
    // Status lags the enable by the oscillator control flop, so let it settle
    osc_is(4'h1);
    apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h0d);
    apb(1'b1, 8'h08, 32'h84); check("slverr", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h08, 32'h0); check("unmapped", rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h0d);
    $display("test status done");
  endtask : test_status
  task automatic test_mid_reset();
    apb(1'b1, 8'h00, 32'h8d);
    osc_is(4'hf);
    check("pins", {20'h0, sense_pin_select}, 32'h20);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    osc_is(4'h0);
    check("pins", {20'h0, sense_pin_select}, 32'h0);
    apb(1'b0, 8'h00, 32'h0); check("control", rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0); check("channel", rd, 32'h0);
    $display("test mid reset done");
  endtask : test_mid_reset
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_channels();
    test_enable_range();
    test_status();
    test_mid_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule : tb_cap_sense_channel_select
`default_nettype wire
